// *** fcsm_defines.vh ***
`ifndef FCSM_DEFINES_VH
`define FCSM_DEFINES_VH

// command codes written into the device command register
`define FCSM_CMD_READ      8'h00
`define FCSM_CMD_IDENT     8'h90
`define FCSM_CMD_ERASE     8'h20
`define FCSM_CMD_EVERIFY   8'hA0
`define FCSM_CMD_PROGRAM   8'h40
`define FCSM_CMD_PVERIFY   8'hC0
`define FCSM_CMD_RESET     8'hFF

// identification addresses
`define FCSM_ID_MFR_ADDR   17'h00000
`define FCSM_ID_DEV_ADDR   17'h00001

// erased byte value
`define FCSM_ERASED        8'hFF

// array geometry
`define FCSM_AW            17
`define FCSM_LAST_ADDR     17'h1FFFF

// host operation codes
`define FCSM_OP_READ       3'h0
`define FCSM_OP_IDENT      3'h1
`define FCSM_OP_ERASE      3'h2
`define FCSM_OP_PROGRAM    3'h3
`define FCSM_OP_RESET      3'h4

// bus cycle phase terminal count; each phase lasts this many clocks plus one
`define FCSM_PHASE_CYC     4'h4

// operation pulse length in clocks (erase and program timing)
`define FCSM_PULSE_CYC     16'h0A00

`endif

// *** fcsm_bus_cycle.v ***
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"

// one strobe cycle on the flash bus: write or read, three phases
module fcsm_bus_cycle (
   input  wire                   clk,
   input  wire                   resetn,
   input  wire                   start,
   input  wire                   wr,
   input  wire [`FCSM_AW-1:0]    addr,
   input  wire [7:0]             wdata,
   input  wire [7:0]             dq_in,
   output reg                    busy_ff,
   output reg                    done_ff,
   output reg  [7:0]             rdata_ff,
   output reg                    ce_n_ff,
   output reg                    we_n_ff,
   output reg                    oe_n_ff,
   output reg  [`FCSM_AW-1:0]    addr_ff,
   output reg  [7:0]             dq_out_ff,
   output reg                    dq_oe_ff
);

   localparam ST_IDLE   = 2'h0;
   localparam ST_SETUP  = 2'h1;
   localparam ST_STROBE = 2'h2;
   localparam ST_HOLD   = 2'h3;

   reg [1:0] state_ff;
   reg [3:0] cnt_ff;
   reg       wr_ff;

   wire cnt_end = (cnt_ff == `FCSM_PHASE_CYC);

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff  <= ST_IDLE;
         cnt_ff    <= 4'h0;
         wr_ff     <= 1'b0;
         busy_ff   <= 1'b0;
         done_ff   <= 1'b0;
         rdata_ff  <= 8'h00;
         ce_n_ff   <= 1'b1;
         we_n_ff   <= 1'b1;
         oe_n_ff   <= 1'b1;
         addr_ff   <= {`FCSM_AW{1'b0}};
         dq_out_ff <= 8'h00;
         dq_oe_ff  <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         cnt_ff  <= cnt_end ? 4'h0 : cnt_ff + 4'h1;
         case (state_ff)
            ST_IDLE: begin
               cnt_ff <= 4'h0;
               if (start) begin
                  state_ff  <= ST_SETUP;
                  busy_ff   <= 1'b1;
                  wr_ff     <= wr;
                  addr_ff   <= addr;
                  dq_out_ff <= wdata;
                  dq_oe_ff  <= wr;
                  ce_n_ff   <= 1'b0;
               end
            end
            ST_SETUP: begin
               if (cnt_end) begin
                  state_ff <= ST_STROBE;
                  // address taken by the device on this falling edge
                  we_n_ff  <= ~wr_ff;
                  oe_n_ff  <= wr_ff;
               end
            end
            ST_STROBE: begin
               if (cnt_end) begin
                  state_ff <= ST_HOLD;
                  // data taken by the device on this rising edge
                  we_n_ff  <= 1'b1;
                  oe_n_ff  <= 1'b1;
                  if (!wr_ff) begin
                     rdata_ff <= dq_in;
                  end
               end
            end
            ST_HOLD: begin
               if (cnt_end) begin
                  // data hold past the strobe before releasing the bus
                  state_ff <= ST_IDLE;
                  ce_n_ff  <= 1'b1;
                  dq_oe_ff <= 1'b0;
                  busy_ff  <= 1'b0;
                  done_ff  <= 1'b1;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// *** fcsm_host.v ***
// How it works
// - leave identification with another valid command
// - verify each byte with its own A0H
// - failed byte: erase again, resume there
// - leave erase verify with valid command
// - host compares verify byte with data
// - two FFH writes, then next command
// - writes need chip select and strobe low
`include "fcsm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module fcsm_host (
   input  wire                   clk,
   input  wire                   resetn,
   input  wire                   vpp_high,
   input  wire                   req,
   input  wire [2:0]             op,
   input  wire [`FCSM_AW-1:0]    req_addr,
   input  wire [7:0]             req_data,
   input  wire [7:0]             dq_in,
   output reg                    busy_ff,
   output reg                    done_ff,
   output reg                    err_ff,
   output reg  [7:0]             rsp_data_ff,
   output reg  [7:0]             rsp_data2_ff,
   output wire                   ce_n,
   output wire                   we_n,
   output wire                   oe_n,
   output wire [`FCSM_AW-1:0]    addr,
   output wire [7:0]             dq_out,
   output wire                   dq_oe
);

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   localparam S_IDLE   = 4'h0;
   localparam S_WR1    = 4'h1;
   localparam S_WR2    = 4'h2;
   localparam S_PULSE  = 4'h3;
   localparam S_VFY    = 4'h4;
   localparam S_VRD    = 4'h5;
   localparam S_RD     = 4'h6;
   localparam S_RD2    = 4'h7;
   localparam S_WR3    = 4'h8;
   localparam S_FIN    = 4'h9;

   reg [3:0]            state_ff;
   reg [2:0]            op_ff;
   reg [`FCSM_AW-1:0]   a_ff;
   reg [`FCSM_AW-1:0]   ea_ff;
   reg [7:0]            d_ff;
   reg [15:0]           tmr_ff;
   reg                  go_ff;
   reg                  cwr_ff;
   reg [`FCSM_AW-1:0]   caddr_ff;
   reg [7:0]            cdata_ff;

   wire                 c_busy;
   wire                 c_done;
   wire [7:0]           c_rdata;

   // ---------------------------------------------------------------
   // bus cycle engine; outputs come straight from its flip-flops
   // ---------------------------------------------------------------
   // strobe with select
   fcsm_bus_cycle u_cyc (
      .clk       (clk),
      .resetn    (resetn),
      .start     (go_ff),
      .wr        (cwr_ff),
      .addr      (caddr_ff),
      .wdata     (cdata_ff),
      .dq_in     (dq_in),
      .busy_ff   (c_busy),
      .done_ff   (c_done),
      .rdata_ff  (c_rdata),
      .ce_n_ff   (ce_n),
      .we_n_ff   (we_n),
      .oe_n_ff   (oe_n),
      .addr_ff   (addr),
      .dq_out_ff (dq_out),
      .dq_oe_ff  (dq_oe)
   );

   wire cyc_free = !c_busy && !go_ff;
   wire tmr_end  = (tmr_ff == `FCSM_PULSE_CYC);
   // ident readout only after its own reads; stops the final 00 write from looping
   wire id_rd    = (op_ff == `FCSM_OP_IDENT) && !cwr_ff && !err_ff;

   // ---------------------------------------------------------------
   // operation sequencer
   // ---------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff     <= S_IDLE;
         op_ff        <= `FCSM_OP_READ;
         a_ff         <= {`FCSM_AW{1'b0}};
         ea_ff        <= {`FCSM_AW{1'b0}};
         d_ff         <= 8'h00;
         tmr_ff       <= 16'h0000;
         go_ff        <= 1'b0;
         cwr_ff       <= 1'b0;
         caddr_ff     <= {`FCSM_AW{1'b0}};
         cdata_ff     <= 8'h00;
         busy_ff      <= 1'b0;
         done_ff      <= 1'b0;
         err_ff       <= 1'b0;
         rsp_data_ff  <= 8'h00;
         rsp_data2_ff <= 8'h00;
      end else begin
         go_ff   <= 1'b0;
         done_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (req) begin
                  busy_ff  <= 1'b1;
                  err_ff   <= 1'b0;
                  op_ff    <= op;
                  a_ff     <= req_addr;
                  d_ff     <= req_data;
                  ea_ff    <= {`FCSM_AW{1'b0}};
                  if (!vpp_high && op != `FCSM_OP_READ) begin
                     err_ff   <= 1'b1;
                     state_ff <= S_FIN;
                  end else begin
                     state_ff <= S_WR1;
                  end
               end
            end
            S_WR1: begin
               if (cyc_free) begin
                  go_ff    <= 1'b1;
                  cwr_ff   <= 1'b1;
                  caddr_ff <= {`FCSM_AW{1'b0}};
                  case (op_ff)
                     `FCSM_OP_READ:    cdata_ff <= `FCSM_CMD_READ;
                     `FCSM_OP_IDENT:   cdata_ff <= `FCSM_CMD_IDENT;
                     `FCSM_OP_ERASE:   cdata_ff <= `FCSM_CMD_ERASE;
                     `FCSM_OP_PROGRAM: cdata_ff <= `FCSM_CMD_PROGRAM;
                     `FCSM_OP_RESET:   cdata_ff <= `FCSM_CMD_RESET;
                     // unknown ops fall back to read
                     default:          cdata_ff <= `FCSM_CMD_READ;
                  endcase
                  state_ff <= (op_ff == `FCSM_OP_READ || op_ff > `FCSM_OP_RESET) ? S_RD :
                              (op_ff == `FCSM_OP_IDENT) ? S_RD : S_WR2;
               end
            end
            S_WR2: begin
               if (cyc_free) begin
                  go_ff  <= 1'b1;
                  cwr_ff <= 1'b1;
                  caddr_ff <= (op_ff == `FCSM_OP_PROGRAM) ? a_ff : {`FCSM_AW{1'b0}};
                  cdata_ff <= (op_ff == `FCSM_OP_ERASE)   ? `FCSM_CMD_ERASE :
                              (op_ff == `FCSM_OP_PROGRAM) ? d_ff : `FCSM_CMD_RESET;
                  tmr_ff   <= 16'h0000;
                  state_ff <= (op_ff == `FCSM_OP_RESET) ? S_WR3 : S_PULSE;
               end
            end
            S_WR3: begin
               if (cyc_free) begin
                  go_ff    <= 1'b1;
                  cwr_ff   <= 1'b1;
                  caddr_ff <= {`FCSM_AW{1'b0}};
                  cdata_ff <= `FCSM_CMD_READ;
                  state_ff <= S_FIN;
               end
            end
            S_PULSE: begin
               if (cyc_free) begin
                  tmr_ff <= tmr_end ? tmr_ff : tmr_ff + 16'h0001;
                  if (tmr_end) begin
                     state_ff <= S_VFY;
                  end
               end
            end
            S_VFY: begin
               if (cyc_free) begin
                  go_ff  <= 1'b1;
                  cwr_ff <= 1'b1;
                  caddr_ff <= (op_ff == `FCSM_OP_ERASE) ? ea_ff : {`FCSM_AW{1'b0}};
                  cdata_ff <= (op_ff == `FCSM_OP_ERASE) ? `FCSM_CMD_EVERIFY :
                              `FCSM_CMD_PVERIFY;
                  state_ff <= S_VRD;
               end
            end
            S_VRD: begin
               if (cyc_free) begin
                  go_ff    <= 1'b1;
                  cwr_ff   <= 1'b0;
                  caddr_ff <= (op_ff == `FCSM_OP_ERASE) ? ea_ff : a_ff;
                  state_ff <= S_RD2;
               end
            end
            S_RD2: begin
               if (c_done) begin
                  rsp_data_ff <= c_rdata;
                  if (op_ff == `FCSM_OP_ERASE) begin
                     if (c_rdata == `FCSM_ERASED) begin
                        if (ea_ff == `FCSM_LAST_ADDR) begin
                           state_ff <= S_WR3;
                        end else begin
                           ea_ff    <= ea_ff + {{(`FCSM_AW-1){1'b0}}, 1'b1};
                           state_ff <= S_VFY;
                        end
                     end else begin
                        state_ff <= S_WR1;
                     end
                  end else begin
                     err_ff   <= (c_rdata != d_ff);
                     state_ff <= S_WR3;
                  end
               end
            end
            S_RD: begin
               // read cycle(s) after the command write
               if (cyc_free) begin
                  go_ff    <= 1'b1;
                  cwr_ff   <= 1'b0;
                  caddr_ff <= (op_ff == `FCSM_OP_IDENT) ? `FCSM_ID_MFR_ADDR : a_ff;
                  state_ff <= S_FIN;
               end
            end
            S_FIN: begin
               if (cyc_free) begin
                  if (id_rd && caddr_ff == `FCSM_ID_MFR_ADDR) begin
                     rsp_data_ff <= c_rdata;
                     go_ff       <= 1'b1;
                     cwr_ff      <= 1'b0;
                     caddr_ff    <= `FCSM_ID_DEV_ADDR;
                  end else if (id_rd && caddr_ff == `FCSM_ID_DEV_ADDR) begin
                     rsp_data2_ff <= c_rdata;
                     go_ff        <= 1'b1;
                     cwr_ff       <= 1'b1;
                     caddr_ff     <= {`FCSM_AW{1'b0}};
                     cdata_ff     <= `FCSM_CMD_READ;
                  end else begin
                     if (op_ff == `FCSM_OP_READ || op_ff > `FCSM_OP_RESET) begin
                        rsp_data_ff <= c_rdata;
                     end
                     busy_ff  <= 1'b0;
                     done_ff  <= 1'b1;
                     state_ff <= S_IDLE;
                  end
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// *** fcsm_host_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"
module fcsm_host_properties (
   input wire logic                clk,
   input wire logic                resetn,
   input wire logic                vpp_high,
   input wire logic                req,
   input wire logic [2:0]          op,
   input wire logic                busy_ff,
   input wire logic                done_ff,
   input wire logic                err_ff,
   input wire logic                ce_n,
   input wire logic                we_n,
   input wire logic                oe_n,
   input wire logic [`FCSM_AW-1:0] addr,
   input wire logic [7:0]          dq_out,
   input wire logic                dq_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ---
   // strobe and bus checks
   // ---
   strobe_excl_a: assert property (we_n || oe_n)
      else $error("write and read strobes low together");
   write_select_a: assert property ($fell(we_n) |-> !ce_n && dq_oe)
      else $error("write strobe without select or drive");
   write_hold_a: assert property (!we_n |=> we_n || ($stable(addr) && $stable(dq_out)))
      else $error("address or data moved under write strobe");
   strobe_width_a: assert property ($fell(we_n) |-> !we_n [*5] ##1 we_n)
      else $error("write strobe width wrong");
   read_drive_a: assert property (!oe_n |-> !ce_n && !dq_oe)
      else $error("read strobe while driving or deselected");
   // ---
   // request checks
   // ---
   refuse_low_a: assert property (req && !busy_ff && !vpp_high && op inside {3'h1, 3'h2, 3'h3, 3'h4}
      |=> ce_n throughout (##[0:4] (done_ff && err_ff)))
      else $error("low supply request not refused");
   done_pulse_a: assert property (done_ff |=> !done_ff)
      else $error("done longer than one cycle");
   busy_start_a: assert property (req && !busy_ff |=> busy_ff)
      else $error("request not taken");
   idle_quiet_a: assert property (!busy_ff && !$past(busy_ff) |-> ce_n && we_n && oe_n && !dq_oe)
      else $error("bus active while idle");
   err_cause_a: assert property ($rose(err_ff) |-> busy_ff ##[1:40] done_ff)
      else $error("error raised without done");
   cover property (done_ff && err_ff);
   cover property ($fell(oe_n));
   cover property ($fell(we_n) && dq_out == `FCSM_CMD_ERASE);
endmodule
bind fcsm_host fcsm_host_properties i_chk (.clk(clk), .resetn(resetn), .vpp_high(vpp_high),
   .req(req), .op(op), .busy_ff(busy_ff), .done_ff(done_ff), .err_ff(err_ff), .ce_n(ce_n),
   .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// *** fcsm_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcsm_flash_model #(
   parameter [7:0] MFR_CODE = 8'h5A,  // arbitrary value
   parameter [7:0] DEV_CODE = 8'hC3   // arbitrary value
) (
   input  wire logic        vpp_high,
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic [16:0] addr,
   input  wire logic [7:0]  dq_out,
   input  wire logic        dq_oe,
   output wire logic [7:0]  dq_in
);
   logic [7:0]  mem [0:131071];
   logic [7:0]  cmd = 8'h00;
   logic [7:0]  rd = 8'h00;
   logic [7:0]  last = 8'h00;
   logic [16:0] wa = 17'h0;
   logic [16:0] pa = 17'h0;
   logic [16:0] weak_addr = 17'h0;
   logic [24:0] wlog [$];
   int          n_erase = 0;
   int          weak_left = 0;
   initial begin
      for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
   end
   always @(negedge vpp_high) cmd = 8'h00;
   always @(negedge we_n) if (!ce_n) wa = addr;
   // next strobe rise ends any operation
   always @(posedge we_n) begin
      if (!ce_n) wlog.push_back({wa, dq_out});
      if (!ce_n && vpp_high) begin
         // byte after set-up programs, only clears bits
         if (cmd == 8'h40 && dq_out != 8'hFF) begin
            mem[wa] = mem[wa] & dq_out;
            pa = wa;
            cmd = 8'h01;
         end
         // second erase code clears whole array, reset aborts
         else if (cmd == 8'h20 && dq_out == 8'h20) begin
            for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
            // one stubborn byte only when a scenario asks for it
            if (weak_left > 0) mem[weak_addr] = 8'hFE;
            weak_left = weak_left - 1;
            n_erase++;
            cmd = 8'h02;
         end
         // other codes just replace the command
         else cmd = dq_out;
      end
   end
   always @(negedge oe_n) begin
      case (cmd)
         8'h90: rd = (addr == 17'h0) ? MFR_CODE : ((addr == 17'h1) ? DEV_CODE : 8'h00);
         8'hA0: rd = mem[wa];
         8'hC0: rd = mem[pa];
         default: rd = mem[addr];
      endcase
   end
   always @(posedge oe_n) last = rd;
   // released bus shows inverse of last byte, no pull-up
   assign dq_in = dq_oe ? dq_out : ((!ce_n && !oe_n) ? rd : ~last);
endmodule
`default_nettype wire

// *** fcsm_host_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"
module fcsm_host_bench;
   typedef struct {
      logic v; logic [2:0] o; logic [16:0] a; logic [7:0] d; logic e;
      logic [7:0] r; logic ck; logic [3:0] nw; logic [7:0] c0; logic [7:0] m;
   } fcsm_row_t;
   localparam logic [7:0] MFR = 8'h5A;  // arbitrary value
   localparam logic [7:0] DEV = 8'hC3;  // arbitrary value
   logic        clk = 1'h0;
   logic        resetn = 1'h0;
   logic        vpp_high = 1'h0;
   logic        req = 1'h0;
   logic [2:0]  op = 3'h0;
   logic [16:0] req_addr = 17'h0;
   logic [7:0]  req_data = 8'h00;
   wire  logic  busy_ff, done_ff, err_ff, ce_n, we_n, oe_n, dq_oe;
   wire  logic [7:0]  dq_in, dq_out, rsp_data_ff, rsp_data2_ff;
   wire  logic [16:0] addr;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          n0;
   int          k;
   logic [7:0]  ecode [9] = '{8'h20, 8'h20, 8'hA0, 8'hA0, 8'hA0, 8'h20, 8'h20, 8'hA0, 8'hA0};
   logic [16:0] eaddr [9] = '{17'h0, 17'h0, 17'h0, 17'h1, 17'h2, 17'h0, 17'h0, 17'h2, 17'h3};
   fcsm_row_t   rows [12] = '{
      '{1'h1, 3'h0, 17'h10, 8'h00, 1'h0, 8'h3C, 1'h1, 4'h1, 8'h00, 8'h3C},
      '{1'h1, 3'h1, 17'h0, 8'h00, 1'h0, MFR, 1'h1, 4'h2, 8'h90, 8'hFF},
      '{1'h1, 3'h4, 17'h0, 8'h00, 1'h0, 8'h00, 1'h0, 4'h3, 8'hFF, 8'hFF},
      '{1'h1, 3'h3, 17'h1234, 8'hA5, 1'h0, 8'hA5, 1'h1, 4'h4, 8'h40, 8'hA5},
      '{1'h1, 3'h3, 17'h1234, 8'h5A, 1'h1, 8'h00, 1'h1, 4'h4, 8'h40, 8'h00},
      '{1'h0, 3'h3, 17'h77, 8'h00, 1'h1, 8'h00, 1'h0, 4'h0, 8'h00, 8'hFF},
      '{1'h0, 3'h2, 17'h0, 8'h00, 1'h1, 8'h00, 1'h0, 4'h0, 8'h00, 8'hFF},
      '{1'h0, 3'h4, 17'h0, 8'h00, 1'h1, 8'h00, 1'h0, 4'h0, 8'h00, 8'hFF},
      '{1'h0, 3'h1, 17'h0, 8'h00, 1'h1, 8'h00, 1'h0, 4'h0, 8'h00, 8'hFF},
      '{1'h0, 3'h0, 17'h1234, 8'h00, 1'h0, 8'h00, 1'h1, 4'h1, 8'h00, 8'h00},
      '{1'h1, 3'h5, 17'h10, 8'h00, 1'h0, 8'h3C, 1'h1, 4'h1, 8'h00, 8'h3C},
      '{1'h1, 3'h3, 17'h77, 8'h3C, 1'h0, 8'h3C, 1'h1, 4'h4, 8'h40, 8'h3C}};

   always #2 clk = ~clk;

   fcsm_host i_dut (.clk(clk), .resetn(resetn), .vpp_high(vpp_high), .req(req), .op(op),
      .req_addr(req_addr), .req_data(req_data), .dq_in(dq_in), .busy_ff(busy_ff),
      .done_ff(done_ff), .err_ff(err_ff), .rsp_data_ff(rsp_data_ff),
      .rsp_data2_ff(rsp_data2_ff), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
      .dq_out(dq_out), .dq_oe(dq_oe));
   fcsm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_mdl (.vpp_high(vpp_high),
      .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_in(dq_in));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // issue one request, held until the next falling edge; does not wait for done
   task automatic start_op(input logic v, input logic [2:0] o, input logic [16:0] a,
                           input logic [7:0] d);
      vpp_high = v;
      op = o;
      req_addr = a;
      req_data = d;
      req = 1'h1;
      @(negedge clk);
      req = 1'h0;
   endtask

   task automatic run_op(input fcsm_row_t r);
      start_op(r.v, r.o, r.a, r.d);
      k = 0;
      while (done_ff !== 1'h1 && k < 4000) begin
         @(negedge clk);
         k++;
      end
      chk("op finish", k < 4000, 1);
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'h1;
      i_mdl.mem[17'h10] = 8'h3C;
      for (int i = 0; i < 12; i++) begin
         n0 = i_mdl.wlog.size();
         run_op(rows[i]);
         chk("error flag", err_ff, rows[i].e);
         if (rows[i].ck) chk("read data", rsp_data_ff, rows[i].r);
         if (rows[i].o == 3'h1) chk("device id", rsp_data2_ff, DEV);
         chk("write count", i_mdl.wlog.size() - n0, rows[i].nw);
         if (rows[i].nw != 4'h0) chk("first code", i_mdl.wlog[n0][7:0], rows[i].c0);
         chk("array byte", i_mdl.mem[rows[i].a], rows[i].m);
      end
      // erase with one byte that needs a second erase
      i_mdl.weak_addr = 17'h2;
      i_mdl.weak_left = 1;
      n0 = i_mdl.wlog.size();
      start_op(1'h1, 3'h2, 17'h0, 8'h00);
      k = 0;
      while (i_mdl.wlog.size() < n0 + 9 && k < 12000) begin
         @(negedge clk);
         k++;
      end
      chk("erase progress", k < 12000, 1);
      for (int i = 0; i < 9; i++) begin
         chk("erase code", i_mdl.wlog[n0 + i][7:0], ecode[i]);
         if (ecode[i] == 8'hA0) chk("verify addr", i_mdl.wlog[n0 + i][24:8], eaddr[i]);
      end
      chk("erase count", i_mdl.n_erase, 2);
      chk("erased byte", i_mdl.mem[17'h1234], 8'hFF);
      // reset in mid-erase must drop the bus at once
      resetn = 1'h0;
      @(negedge clk);
      chk("bus in reset", {busy_ff, ce_n, we_n, oe_n, dq_oe}, 5'h0E);
      resetn = 1'h1;
      @(negedge clk);
      run_op(rows[0]);
      chk("read after reset", rsp_data_ff, 8'hFF);
      complete_run();
   end
endmodule
`default_nettype wire
